// >>> dprr_device.sv
// Device end: mode registers, pattern pages and read burst engine
// Overview of operation
// - Parity error log page only in pattern mode
// - Controller ignores page one location two bit one
// - Single die: location three low bits ignored
// - Location three low bits show parity latency
// - Temperature field codes refresh rate range
// - Temperature data never older than 32 ms
// - Readout disabled freezes temperature field
// - Strobes with preamble as normal reads
// - Page zero reads may use short spacing
// - Other pages need long read spacing
// - Lock loop, precharge all, wait before entry
// - Mode three bits 12:11 select format
// - Mode three low bits select page, wait
// - Bank address selects location
// - Only BL8 or BC4 reads, fixed or on-the-fly
// - On-the-fly setting: burst chop bit high
// - Address bit two sets burst order
// - Low column bits zero, others ignored
// - Burst starts after AL plus CL
// - Exit: wait, clear access bit, wait
// - Serial: same sequence on every lane
// - Parallel: bits across lanes, repeated
// - Staggered: lane n shows location n+k
`timescale 1ns/1ps
module dprr_device #(
  parameter int unsigned TEMP_UPDATE_CYC = dprr_pkg::TEMP_UPDATE_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  dprr_if.device           link,
  input  wire logic [1:0]  tempRate,
  input  wire logic        errLogStrobe,
  input  wire logic [23:0] errLogWord,
  input  wire logic        crcErr,
  output logic             patternModeOn,
  output logic [1:0]       tempStatus
);
  logic [dprr_pkg::ADDR_W-1:0] modeReg_q [dprr_pkg::MR_CNT];
  logic [2:0]                  mrIdx;
  logic [dprr_pkg::ADDR_W-1:0] mr0, mr1, mr2, mr3, mr4, mr5, mr6;
  logic [23:0]                 errLog_q;
  logic                        caFlag_q, crcFlag_q;
  logic [1:0]                  tempS1_q, tempS2_q, tempS3_q;
  logic [1:0]                  tempStable_q, temp_q;
  logic [dprr_pkg::TEMP_CNT_W-1:0] tempCnt_q;
  dprr_pkg::dprr_desc_t        line_q [dprr_pkg::RL_MAX];
  dprr_pkg::dprr_desc_t        newDesc, tap;
  logic [5:0]                  cl, al, rl;
  logic                        pre2, preOn, rdHit;
  logic [31:0]                 page0W, page1W, page2W, tapBytes;
  logic [31:0]                 burstBytes_q, srcBytes;
  logic [1:0]                  burstLoc_q, burstFmt_q, srcLoc, srcFmt;
  logic                        burstChop_q, busy_q;
  logic [2:0]                  beatIdx_q, ui_q, srcUi;
  logic                        lastBeat, dataNext;
  logic [dprr_pkg::DQ_W-1:0]   fmtBits, dq_q;
  logic                        dqOe_q, dqs_q, dqsOe_q;

  assign mrIdx = {link.cmdBg[0], link.cmdBa};
  assign mr0 = modeReg_q[0];
  assign mr1 = modeReg_q[1];
  assign mr2 = modeReg_q[2];
  assign mr3 = modeReg_q[3];
  assign mr4 = modeReg_q[4];
  assign mr5 = modeReg_q[5];
  assign mr6 = modeReg_q[6];

  // Mode register writes; everything returns to zero on re-initialization
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int m = 0; m < dprr_pkg::MR_CNT; m++) begin
        modeReg_q[m] <= '0;
      end
    end else if (link.cmdValid && link.cmd == dprr_pkg::DPRR_CMD_MRS &&
                 mrIdx < 3'(dprr_pkg::MR_CNT)) begin
      modeReg_q[mrIdx] <= link.cmdAddr;
    end
  end

  // Error log capture; flags are sticky until re-initialization
  always_ff @(posedge clk) begin
    if (!nrst) begin
      errLog_q  <= '0;
      caFlag_q  <= 1'b0;
      crcFlag_q <= 1'b0;
    end else begin
      if (errLogStrobe) begin
        errLog_q <= errLogWord;
        caFlag_q <= 1'b1;
      end
      if (crcErr) begin
        crcFlag_q <= 1'b1;
      end
    end
  end

  // Sensor code comes from another domain: three stages, accepted on agree
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tempS1_q     <= '0;
      tempS2_q     <= '0;
      tempS3_q     <= '0;
      tempStable_q <= '0;
    end else begin
      tempS1_q <= tempRate;
      tempS2_q <= tempS1_q;
      tempS3_q <= tempS2_q;
      if (tempS2_q == tempS3_q) begin
        tempStable_q <= tempS3_q;
      end
    end
  end

  // Sample at once on enable, then once per age period
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tempCnt_q <= '0;
      temp_q    <= '0;
    end else if (mr3[dprr_pkg::MR3_TEMP_EN]) begin
      if (tempCnt_q == '0) begin
        temp_q    <= tempStable_q;
        tempCnt_q <= dprr_pkg::TEMP_CNT_W'(TEMP_UPDATE_CYC - 1);
      end else begin
        tempCnt_q <= tempCnt_q - 1'b1;
      end
    end else begin
      tempCnt_q <= '0;
    end
  end

  // Page contents, location three in the top byte
  always_comb begin
    page0W = dprr_pkg::PAGE0_RST;
    page1W = {crcFlag_q, caFlag_q, 3'h0,
              mr5[dprr_pkg::MR5_PL_LSB +: 3],
              errLog_q};
    page2W = {mr1[10:8], mr5[8:6], mr1[2:1],
              mr0[6:4], mr0[2], 1'b0, mr2[5:3],
              mr6[6:0], mr3[dprr_pkg::MR3_GEARDOWN],
              3'h0, temp_q, mr2[12], mr2[10:9]};
  end

  // Read latency is additive plus CAS latency
  always_comb begin
    cl = dprr_pkg::CL_BASE + {3'h0, mr0[dprr_pkg::MR0_CL_LSB +: 3]};
    case (mr1[dprr_pkg::MR1_AL_LSB +: 2])
      2'h1:    al = cl - 6'h01;
      2'h2:    al = cl - 6'h02;
      default: al = 6'h00;
    endcase
    rl   = al + cl;
    pre2 = mr4[dprr_pkg::MR4_PRE_BIT];
  end

  // Reads are taken only while the pattern access bit is set
  always_comb begin
    rdHit = link.cmdValid && link.cmd == dprr_pkg::DPRR_CMD_RD &&
            mr3[dprr_pkg::MR3_ACCESS_BIT];
    newDesc.v     = rdHit;
    newDesc.page  = mr3[dprr_pkg::MR3_PAGE_LSB +: 2];
    newDesc.loc   = link.cmdBa;
    newDesc.fmt   = mr3[dprr_pkg::MR3_FMT_LSB +: 2];
    newDesc.order = link.cmdAddr[dprr_pkg::ADDR_ORDER_BIT];
    newDesc.chop  = mr0[1:0] == dprr_pkg::BL_FIXED4 ||
                    (mr0[1:0] == dprr_pkg::BL_OTF &&
                     !link.cmdAddr[dprr_pkg::ADDR_BC_BIT]);
  end

  // Latency line: entry k is seen k+1 cycles after the command
  always_ff @(posedge clk) begin
    if (!nrst) begin
      line_q[0] <= '0;
    end else begin
      line_q[0] <= newDesc;
    end
  end

  for (genvar k = 1; k < dprr_pkg::RL_MAX; k++) begin : g_line
    always_ff @(posedge clk) begin
      if (!nrst) begin
        line_q[k] <= '0;
      end else begin
        line_q[k] <= line_q[k-1];
      end
    end
  end

  // Taps land the first beat on the pins exactly RL cycles after the read
  always_comb begin
    tap   = line_q[5'(rl - 6'h02)];
    preOn = line_q[5'(rl - 6'h03)].v ||
            (pre2 && line_q[5'(rl - 6'h04)].v);
    case (tap.page)
      2'h0:    tapBytes = page0W;
      2'h1:    tapBytes = page1W;
      2'h2:    tapBytes = page2W;
      default: tapBytes = '0;
    endcase
  end

  always_comb begin
    lastBeat = beatIdx_q == 3'h7;
    if (tap.v) begin
      srcBytes = tapBytes;
      srcLoc   = tap.loc;
      srcFmt   = tap.fmt;
      srcUi    = {tap.order, 2'h0};
      dataNext = 1'b1;
    end else begin
      srcBytes = burstBytes_q;
      srcLoc   = burstLoc_q;
      srcFmt   = burstFmt_q;
      srcUi    = ui_q + 3'h1;
      // Chopped bursts leave the last four beats undriven
      dataNext = busy_q && !lastBeat &&
                 !(burstChop_q && beatIdx_q >= 3'h3);
    end
  end

  dprr_burst_fmt u_fmt (
    .locBytes (srcBytes),
    .loc      (srcLoc),
    .fmt      (srcFmt),
    .ui       (srcUi),
    .laneBits (fmtBits)
  );

  // A new burst may start on the beat after the last one, so no gap
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_q       <= 1'b0;
      beatIdx_q    <= '0;
      ui_q         <= '0;
      burstBytes_q <= '0;
      burstLoc_q   <= '0;
      burstFmt_q   <= '0;
      burstChop_q  <= 1'b0;
    end else if (tap.v) begin
      busy_q       <= 1'b1;
      beatIdx_q    <= '0;
      ui_q         <= srcUi;
      burstBytes_q <= tapBytes;
      burstLoc_q   <= tap.loc;
      burstFmt_q   <= tap.fmt;
      burstChop_q  <= tap.chop;
    end else if (busy_q) begin
      busy_q    <= !lastBeat;
      beatIdx_q <= beatIdx_q + 3'h1;
      ui_q      <= srcUi;
    end
  end

  // Strobe toggles with data; preamble holds it low ahead of the burst
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dq_q    <= '0;
      dqOe_q  <= 1'b0;
      dqs_q   <= 1'b0;
      dqsOe_q <= 1'b0;
    end else begin
      dq_q    <= dataNext ? fmtBits : '0;
      dqOe_q  <= dataNext;
      // Beat counter names the beat now out, so the next one is even if odd
      dqs_q   <= dataNext && (tap.v || beatIdx_q[0]);
      dqsOe_q <= dataNext || preOn;
    end
  end

  assign link.dq       = dq_q;
  assign link.dqOe     = dqOe_q;
  assign link.dqs      = dqs_q;
  assign link.dqsOe    = dqsOe_q;
  assign patternModeOn = modeReg_q[3][dprr_pkg::MR3_ACCESS_BIT];
  assign tempStatus    = temp_q;
endmodule

// >>> dprr_pkg.sv
// Shared constants and types for the pattern register readout link
package dprr_pkg;

  localparam int DQ_W   = 16;
  localparam int ADDR_W = 18;
  localparam int MR_CNT = 7;
  localparam int RL_MAX = 32;
  localparam int WAIT_W = 8;

  typedef enum logic [1:0] {
    DPRR_CMD_NOP,
    DPRR_CMD_MRS,
    DPRR_CMD_RD,
    DPRR_CMD_PREA
  } dprr_cmd_t;

  // Mode register three fields
  localparam int MR3_PAGE_LSB   = 0;
  localparam int MR3_ACCESS_BIT = 2;
  localparam int MR3_GEARDOWN   = 3;
  localparam int MR3_TEMP_EN    = 5;
  localparam int MR3_FMT_LSB    = 11;
  localparam logic [2:0] MR3_INDEX = 3'h3;

  // Mode register zero, one, four, five fields
  localparam int MR0_BL_LSB  = 0;
  localparam int MR0_CL_LSB  = 4;
  localparam int MR1_AL_LSB  = 3;
  localparam int MR4_PRE_BIT = 11;
  localparam int MR5_PL_LSB  = 0;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  // Read command address bits
  localparam int ADDR_ORDER_BIT = 2;
  localparam int ADDR_BC_BIT    = 12;

  localparam logic [1:0] FMT_SERIAL   = 2'h0;
  localparam logic [1:0] FMT_PARALLEL = 2'h1;
  localparam logic [1:0] FMT_STAGGER  = 2'h2;

  // Training pattern reset contents, location three down to zero
  localparam logic [31:0] PAGE0_RST = 32'h000f3355;

  localparam logic [5:0] CL_BASE = 6'h09;
  localparam logic [7:0] BEATS_BL8 = 8'h08;
  localparam logic [7:0] BEATS_BC4 = 8'h04;

  // Timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int T_RP_PS       = 13750;
  localparam logic [WAIT_W-1:0] T_RP_CYC =
    WAIT_W'((T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [WAIT_W-1:0] T_MRD_NCK  = 8'h08;
  localparam logic [WAIT_W-1:0] T_MOD_NCK  = 8'h18;
  localparam logic [WAIT_W-1:0] T_MPRR_NCK = 8'h01;
  localparam logic [WAIT_W-1:0] T_CCD_S    = 8'h08;
  localparam logic [WAIT_W-1:0] T_CCD_L    = 8'h0a;
  localparam longint unsigned TEMP_AGE_MS = 64'd32;
  localparam int unsigned TEMP_UPDATE_CYC =
    int'(TEMP_AGE_MS * 64'd1000000000 / 64'(CLK_PERIOD_PS));
  localparam int TEMP_CNT_W = 22;

  typedef struct packed {
    logic       v;
    logic [1:0] page;
    logic [1:0] loc;
    logic [1:0] fmt;
    logic       order;
    logic       chop;
  } dprr_desc_t;

endpackage

// >>> dprr_if.sv
// Command and data pins between controller and pattern readout device
`timescale 1ns/1ps
interface dprr_if;
  logic                        cmdValid;
  dprr_pkg::dprr_cmd_t         cmd;
  logic [1:0]                  cmdBg;
  logic [1:0]                  cmdBa;
  logic [dprr_pkg::ADDR_W-1:0] cmdAddr;
  logic [dprr_pkg::DQ_W-1:0]   dq;
  logic                        dqOe;
  logic                        dqs;
  logic                        dqsOe;

  modport device (
    input  cmdValid,
    input  cmd,
    input  cmdBg,
    input  cmdBa,
    input  cmdAddr,
    output dq,
    output dqOe,
    output dqs,
    output dqsOe
  );

  modport ctrl (
    output cmdValid,
    output cmd,
    output cmdBg,
    output cmdBa,
    output cmdAddr,
    input  dq,
    input  dqOe,
    input  dqs,
    input  dqsOe
  );
endinterface

// >>> dprr_burst_fmt.sv
// Lane mapping of one burst beat for serial, parallel and staggered layout
`timescale 1ns/1ps
module dprr_burst_fmt (
  input  wire logic [31:0]               locBytes,
  input  wire logic [1:0]                loc,
  input  wire logic [1:0]                fmt,
  input  wire logic [2:0]                ui,
  output logic      [dprr_pkg::DQ_W-1:0] laneBits
);
  // UI k carries byte bit 7-k, which is ~k on three bits
  for (genvar i = 0; i < dprr_pkg::DQ_W; i++) begin : g_lane
    localparam logic [2:0] PAR_BIT = 3'(7 - (i % 8));
    localparam logic [1:0] STG_OFS = 2'(i % 4);
    logic [1:0] stagLoc;
    assign stagLoc = loc + STG_OFS;
    always_comb begin
      if (fmt == dprr_pkg::FMT_PARALLEL) begin
        laneBits[i] = locBytes[{loc, PAR_BIT}];
      end else if (fmt == dprr_pkg::FMT_STAGGER) begin
        laneBits[i] = locBytes[{stagLoc, ~ui}];
      end else begin
        laneBits[i] = locBytes[{loc, ~ui}];
      end
    end
  end
endmodule

// >>> dprr_ctrl.sv
// Controller end: pattern mode entry, reads with spacing, capture, exit
`timescale 1ns/1ps
module dprr_ctrl (
  input  wire logic       clk,
  input  wire logic       nrst,
  dprr_if.ctrl            link,
  input  wire logic       dllLocked,
  input  wire logic [1:0] burstField,
  input  wire logic       enterReq,
  input  wire logic [1:0] enterPage,
  input  wire logic [1:0] enterFmt,
  input  wire logic       tempReadEn,
  input  wire logic       readReq,
  input  wire logic [1:0] readLoc,
  input  wire logic       readHiFirst,
  input  wire logic       exitReq,
  output logic            ready,
  output logic            rdValid,
  output logic [7:0]      rdByte
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT_RP, ST_SET_MODE, ST_WAIT_MOD, ST_READY,
    ST_RD_WAIT, ST_EXIT_WAIT, ST_EXIT_MRS, ST_EXIT_MOD
  } dprr_state_t;

  dprr_state_t                  state_q;
  logic [dprr_pkg::WAIT_W-1:0]  wait_q;
  logic                         cmdValid_q;
  dprr_pkg::dprr_cmd_t          cmd_q;
  logic [1:0]                   cmdBa_q, page_q, fmt_q, rdLoc_q;
  logic [dprr_pkg::ADDR_W-1:0]  cmdAddr_q, mr3Val;
  logic                         tempEn_q, order_q, pend_q, chop;
  logic [2:0]                   beat_q;
  logic [7:0]                   cap_q, capNext, masked;
  logic                         ready_q, rdValid_q;
  logic [7:0]                   rdByte_q;

  assign chop = burstField == dprr_pkg::BL_FIXED4;

  always_comb begin
    mr3Val = '0;
    mr3Val[dprr_pkg::MR3_PAGE_LSB +: 2] = page_q;
    mr3Val[dprr_pkg::MR3_FMT_LSB +: 2]  = fmt_q;
    mr3Val[dprr_pkg::MR3_TEMP_EN]       = tempEn_q;
    mr3Val[dprr_pkg::MR3_ACCESS_BIT]    = state_q == ST_SET_MODE;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q    <= ST_IDLE;
      wait_q     <= '0;
      cmdValid_q <= 1'b0;
      cmd_q      <= dprr_pkg::DPRR_CMD_NOP;
      cmdBa_q    <= '0;
      cmdAddr_q  <= '0;
      page_q     <= '0;
      fmt_q      <= '0;
      tempEn_q   <= 1'b0;
      rdLoc_q    <= '0;
      order_q    <= 1'b0;
    end else begin
      cmdValid_q <= 1'b0;
      cmd_q      <= dprr_pkg::DPRR_CMD_NOP;
      if (wait_q != '0) begin
        wait_q <= wait_q - 1'b1;
      end
      case (state_q)
        ST_IDLE: if (enterReq && dllLocked) begin
          page_q     <= enterPage;
          fmt_q      <= enterFmt;
          tempEn_q   <= tempReadEn;
          cmdValid_q <= 1'b1;
          cmd_q      <= dprr_pkg::DPRR_CMD_PREA;
          wait_q     <= dprr_pkg::T_RP_CYC;
          state_q    <= ST_WAIT_RP;
        end
        ST_WAIT_RP: if (wait_q == '0) begin
          state_q <= ST_SET_MODE;
        end
        ST_SET_MODE, ST_EXIT_MRS: begin
          cmdValid_q <= 1'b1;
          cmd_q      <= dprr_pkg::DPRR_CMD_MRS;
          cmdBa_q    <= dprr_pkg::MR3_INDEX[1:0];
          cmdAddr_q  <= mr3Val;
          // Mode delays run back to back after the write
          wait_q     <= dprr_pkg::T_MRD_NCK + dprr_pkg::T_MOD_NCK;
          state_q    <= state_q == ST_SET_MODE ? ST_WAIT_MOD : ST_EXIT_MOD;
        end
        ST_WAIT_MOD: if (wait_q == '0) begin
          state_q <= ST_READY;
        end
        ST_READY: begin
          if (exitReq) begin
            wait_q  <= dprr_pkg::T_MPRR_NCK;
            state_q <= ST_EXIT_WAIT;
          end else if (readReq) begin
            cmdValid_q <= 1'b1;
            cmd_q      <= dprr_pkg::DPRR_CMD_RD;
            // Parallel layout is defined for location zero only
            cmdBa_q    <= fmt_q == dprr_pkg::FMT_PARALLEL ?
                          2'h0 : readLoc;
            rdLoc_q    <= fmt_q == dprr_pkg::FMT_PARALLEL ?
                          2'h0 : readLoc;
            cmdAddr_q  <= '0;
            cmdAddr_q[dprr_pkg::ADDR_ORDER_BIT] <= readHiFirst;
            cmdAddr_q[dprr_pkg::ADDR_BC_BIT] <=
              burstField == dprr_pkg::BL_OTF;
            order_q    <= readHiFirst;
            wait_q     <= page_q == 2'h0 ?
                          dprr_pkg::T_CCD_S : dprr_pkg::T_CCD_L;
            state_q    <= ST_RD_WAIT;
          end
        end
        ST_RD_WAIT: if (wait_q == '0 && !pend_q) begin
          state_q <= ST_READY;
        end
        ST_EXIT_WAIT: if (wait_q == '0) begin
          state_q <= ST_EXIT_MRS;
        end
        ST_EXIT_MOD: if (wait_q == '0) begin
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Gather lane zero per beat; parallel takes lanes 0 to 7 of the first beat
  always_comb begin
    capNext = cap_q;
    if (fmt_q == dprr_pkg::FMT_PARALLEL) begin
      if (beat_q == 3'h0) begin
        for (int i = 0; i < 8; i++) begin
          capNext[7 - i] = link.dq[i];
        end
      end
    end else begin
      capNext[~(beat_q ^ {order_q, 2'h0})] = link.dq[0];
    end
    masked = capNext;
    if (page_q == 2'h1 && rdLoc_q == 2'h2) begin
      masked[1] = 1'b0;
    end
    if (page_q == 2'h1 && rdLoc_q == 2'h3) begin
      masked[2:0] = 3'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pend_q    <= 1'b0;
      beat_q    <= '0;
      cap_q     <= '0;
      rdValid_q <= 1'b0;
      rdByte_q  <= '0;
    end else begin
      rdValid_q <= 1'b0;
      if (cmdValid_q && cmd_q == dprr_pkg::DPRR_CMD_RD) begin
        pend_q <= 1'b1;
        beat_q <= '0;
        cap_q  <= '0;
      end else if (pend_q && link.dqOe) begin
        cap_q  <= capNext;
        beat_q <= beat_q + 3'h1;
        if ({5'h0, beat_q} + 8'h01 ==
            (chop ? dprr_pkg::BEATS_BC4 : dprr_pkg::BEATS_BL8)) begin
          pend_q    <= 1'b0;
          rdValid_q <= 1'b1;
          rdByte_q  <= masked;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= state_q == ST_READY;
    end
  end

  assign link.cmdValid = cmdValid_q;
  assign link.cmd      = cmd_q;
  assign link.cmdBg    = '0;
  assign link.cmdBa    = cmdBa_q;
  assign link.cmdAddr  = cmdAddr_q;
  assign ready         = ready_q;
  assign rdValid       = rdValid_q;
  assign rdByte        = rdByte_q;
endmodule

// >>> dprr_link_properties.sv
// Concurrent checks on the link pins between controller and device
`timescale 1ns/1ps
module dprr_link_properties (
  input wire logic                        clk,
  input wire logic                        nrst,
  input wire logic                        cmdValid,
  input wire dprr_pkg::dprr_cmd_t         cmd,
  input wire logic [1:0]                  cmdBg,
  input wire logic [1:0]                  cmdBa,
  input wire logic [dprr_pkg::ADDR_W-1:0] cmdAddr,
  input wire logic [dprr_pkg::DQ_W-1:0]   dq,
  input wire logic                        dqOe,
  input wire logic                        dqs,
  input wire logic                        dqsOe
);
  logic       rdCmd;
  logic       mr3Wr;
  logic       modeOn_q;
  logic [1:0] page_q;
  logic [1:0] fmt_q;
  logic [7:0] gap_q;

  assign rdCmd = cmdValid && cmd == dprr_pkg::DPRR_CMD_RD;
  assign mr3Wr = cmdValid && cmd == dprr_pkg::DPRR_CMD_MRS &&
                 {cmdBg[0], cmdBa} == dprr_pkg::MR3_INDEX;

  // Mirror of the mode register three access, page and format fields the device acts on
  always_ff @(posedge clk) begin
    if (!nrst) begin
      modeOn_q <= 1'b0;
      page_q   <= 2'h0;
      fmt_q    <= 2'h0;
    end else if (mr3Wr) begin
      modeOn_q <= cmdAddr[dprr_pkg::MR3_ACCESS_BIT];
      page_q   <= cmdAddr[dprr_pkg::MR3_PAGE_LSB +: 2];
      fmt_q    <= cmdAddr[dprr_pkg::MR3_FMT_LSB +: 2];
    end
  end

  // Cycles since the last read; saturates so long idle spans stay legal
  always_ff @(posedge clk) begin
    if (!nrst) begin
      gap_q <= 8'hff;
    end else if (rdCmd) begin
      gap_q <= 8'h01;
    end else if (gap_q != 8'hff) begin
      gap_q <= gap_q + 8'h01;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_preamble;
    !dqs && !dqOe ##1 dqOe && dqs;
  endsequence
  sequence s_burst;
    dqOe [*8];
  endsequence

  // Other mode registers stay zero, so latency is the base CL of 9
  a_read_latency: assert property (rdCmd && modeOn_q |-> ##9 s_burst)
    else $error("burst late after read");
  a_strobe_preamble: assert property ($rose(dqsOe) |-> s_preamble)
    else $error("strobe preamble missing");
  a_strobe_toggle: assert property (dqOe && $past(dqOe)
    |-> dqs != $past(dqs)) else $error("strobe did not toggle");
  a_serial_lanes: assert property (dqOe && fmt_q[0] == fmt_q[1]
    |-> dq == {16{dq[0]}}) else $error("serial lanes differ");
  a_parallel_repeat: assert property (dqOe && $past(dqOe)
    && fmt_q == dprr_pkg::FMT_PARALLEL |-> $stable(dq))
    else $error("parallel beat changed");
  a_byte_halves: assert property (dqOe |-> dq[15:8] == dq[7:0])
    else $error("byte halves differ");
  a_read_addr_low: assert property (rdCmd |-> cmdAddr[1:0] == 2'h0)
    else $error("read low column bits set");
  a_parallel_loc: assert property (rdCmd
    && fmt_q == dprr_pkg::FMT_PARALLEL |-> cmdBa == 2'h0)
    else $error("parallel read off location zero");
  a_long_spacing: assert property (rdCmd && page_q != 2'h0
    |-> gap_q >= dprr_pkg::T_CCD_L) else $error("reads too close");
  a_exit_quiet: assert property (mr3Wr && modeOn_q
    && !cmdAddr[dprr_pkg::MR3_ACCESS_BIT] |-> !dqOe && !$past(dqOe))
    else $error("exit during burst");
endmodule

// >>> dram_pattern_register_readout_tb_top.sv
// Bench joining controller and device, checked against a byte model
`timescale 1ns/1ps
module dram_pattern_register_readout_tb_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        dllLocked = 1'b0;
  logic        enterReq = 1'b0;
  logic        tempReadEn = 1'b0;
  logic        readReq = 1'b0;
  logic        readHiFirst = 1'b0;
  logic        exitReq = 1'b0;
  logic        errLogStrobe = 1'b0;
  logic        crcErr = 1'b0;
  logic [1:0]  burstField = 2'h0;
  logic [1:0]  enterPage = 2'h0;
  logic [1:0]  enterFmt = 2'h0;
  logic [1:0]  readLoc = 2'h0;
  logic [1:0]  tempRate = 2'h0;
  logic [23:0] errLogWord = 24'h0;
  logic        patternModeOn, ready, rdValid;
  logic [1:0]  tempStatus;
  logic [7:0]  rdByte;
  logic        beats[$];
  int          err_total = 0;
  int          n_compared = 0;
  int          caF = 0, crcF = 0, tmp = 0, pg = 0, fm = 0;

  always #4 clk = ~clk;

  dprr_if link ();
  dprr_device #(.TEMP_UPDATE_CYC(16)) i_dprr_device (.clk(clk),
    .nrst(nrst), .link(link), .tempRate(tempRate),
    .errLogStrobe(errLogStrobe), .errLogWord(errLogWord), .crcErr(crcErr),
    .patternModeOn(patternModeOn), .tempStatus(tempStatus));
  dprr_ctrl i_dprr_ctrl (.clk(clk), .nrst(nrst), .link(link),
    .dllLocked(dllLocked), .burstField(burstField), .enterReq(enterReq),
    .enterPage(enterPage), .enterFmt(enterFmt), .tempReadEn(tempReadEn),
    .readReq(readReq), .readLoc(readLoc), .readHiFirst(readHiFirst),
    .exitReq(exitReq), .ready(ready), .rdValid(rdValid), .rdByte(rdByte));
  dprr_link_properties i_dprr_link_properties (.clk(clk), .nrst(nrst),
    .cmdValid(link.cmdValid), .cmd(link.cmd), .cmdBg(link.cmdBg),
    .cmdBa(link.cmdBa), .cmdAddr(link.cmdAddr), .dq(link.dq),
    .dqOe(link.dqOe), .dqs(link.dqs), .dqsOe(link.dqsOe));

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Sel 0: ready high, 1: rdValid high, 2: ready low
  task automatic wait_hi(int sel, int lim);
    int i = 0;
    while ((sel == 2) ? ready !== 1'b0 : (sel ? rdValid : ready) !== 1'b1)
    begin
      @(negedge clk);
      i++;
      if (i > lim) begin
        chk("wait bound", 1, 0);
        results();
      end
    end
  endtask

  function automatic logic [7:0] dev_byte(int p, int l);
    case (p)
      0: return dprr_pkg::PAGE0_RST[8 * l +: 8];
      1: return (l == 3) ? {crcF[0], caF[0], 6'h0} : errLogWord[8 * l +: 8];
      2: return (l == 0) ? {3'h0, tmp[1:0], 3'h0} : 8'h0;
      default: return 8'h0;
    endcase
  endfunction

  task automatic enter(int p, int f, int t);
    @(posedge clk);
    enterReq <= 1'b1;
    enterPage <= p[1:0];
    enterFmt <= f[1:0];
    tempReadEn <= t[0];
    pg = p;
    fm = f;
    @(posedge clk);
    enterReq <= 1'b0;
    wait_hi(0, 100);
    chk("mode on", patternModeOn, 1);
  endtask

  task automatic leave();
    wait_hi(0, 50);
    @(posedge clk);
    exitReq <= 1'b1;
    @(posedge clk);
    exitReq <= 1'b0;
    wait_hi(2, 100);
    // Exit write and mode delay must finish before the next entry
    repeat (40) @(negedge clk);
    chk("mode off", patternModeOn, 0);
  endtask

  task automatic rd(int l);
    logic [7:0] b, w, m, e;
    logic hf;
    int lc;
    wait_hi(0, 100);
    lc = (fm == 1) ? 0 : l;
    b = dev_byte(pg, lc);
    hf = 1'($urandom_range(1));
    beats.delete();
    @(posedge clk);
    readReq <= 1'b1;
    readLoc <= l[1:0];
    readHiFirst <= hf;
    // Only fixed BL8 or on-the-fly settings; chop is not exercised
    burstField <= 2'($urandom_range(1));
    @(posedge clk);
    readReq <= 1'b0;
    wait_hi(1, 60);
    m = (pg != 1) ? 8'hff : (lc == 2) ? 8'hfd : (lc == 3) ? 8'hf8 : 8'hff;
    chk("rd byte", rdByte, b & m);
    w = 8'h0;
    for (int i = 0; i < 8 && i < beats.size(); i++) begin
      w[7 - i] = beats[i];
    end
    e = (fm == 1) ? {8{b[7]}} : hf ? {b[3:0], b[7:4]} : b;
    chk("beats", beats.size(), 8);
    chk("lane0", w, e);
  endtask

  always @(negedge clk) begin
    if (link.dqOe === 1'b1) begin
      beats.push_back(link.dq[0]);
      chk("halves", link.dq[15:8], link.dq[7:0]);
    end
  end

  initial begin
    int r;
    void'($urandom(32'h60c6d5dc));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    enterReq <= 1'b1;
    @(posedge clk);
    enterReq <= 1'b0;
    repeat (40) @(negedge clk);
    chk("no entry unlocked", patternModeOn, 0);
    @(posedge clk);
    dllLocked <= 1'b1;
    $display("test unlocked entry done");
    for (int f = 0; f < 4; f++) begin
      enter(0, f, 0);
      for (int l = 0; l < 4; l++) rd(l);
      leave();
    end
    $display("test formats done");
    @(posedge clk);
    errLogWord <= 24'($urandom);
    errLogStrobe <= 1'b1;
    crcErr <= 1'b1;
    @(posedge clk);
    errLogStrobe <= 1'b0;
    crcErr <= 1'b0;
    caF = 1;
    crcF = 1;
    enter(1, 0, 0);
    for (int l = 0; l < 4; l++) rd(l);
    leave();
    $display("test error log done");
    r = $urandom_range(2);
    tmp = r;
    @(posedge clk);
    tempRate <= r[1:0];
    enter(2, 0, 1);
    chk("temp", tempStatus, tmp);
    rd(0);
    tmp = (tmp + 1) % 3;
    @(posedge clk);
    tempRate <= tmp[1:0];
    repeat (24) @(negedge clk);
    chk("temp update", tempStatus, tmp);
    rd(0);
    leave();
    // Exit keeps readout enabled; re-entry with it off freezes the field
    enter(2, 0, 0);
    @(posedge clk);
    tempRate <= 2'((tmp + 1) % 3);
    repeat (40) @(negedge clk);
    chk("temp hold", tempStatus, tmp);
    rd(0);
    leave();
    $display("test temperature done");
    enter(3, 2, 0);
    rd($urandom_range(3));
    leave();
    $display("test spare page done");
    results();
  end
endmodule
